// file: tdi_pkg.sv
package tdi_pkg;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 2048;
  localparam int MEM_AW = 11;
  localparam int ROW_W = 6;
  localparam int FIFO_DEPTH = 4;
  localparam logic [4:0] RAM_BLK1_HI = 5'h02;
  localparam logic [4:0] RAM_BLKF_HI = 5'h1E;
  localparam logic [9:0] CON_BLK1_HI = 10'h061;
  localparam logic [9:0] CON_BLKE_HI = 10'h3A1;
  localparam int SYS_CLK_MHZ = 250;
  localparam int DOT_CLK_MHZ = 12;
  localparam int DOT_CYC = SYS_CLK_MHZ / DOT_CLK_MHZ;
  localparam int DOTS_PER_CELL = 6;
  localparam int NUM_REGS = 19;
  localparam logic [7:0] HTOT_RST = 8'h65;
  localparam logic [7:0] HDISP_RST = 8'h50;
  localparam logic [7:0] HSPOS_RST = 8'h56;
  localparam logic [7:0] SYNCW_RST = 8'h29;
  localparam logic [7:0] VTOT_RST = 8'h1E;
  localparam logic [7:0] VDISP_RST = 8'h19;
  localparam logic [7:0] VSPOS_RST = 8'h1B;
  localparam logic [7:0] MAXSCAN_RST = 8'h09;
  localparam int REG_HTOT = 0;
  localparam int REG_HDISP = 1;
  localparam int REG_HSPOS = 2;
  localparam int REG_SYNCW = 3;
  localparam int REG_VTOT = 4;
  localparam int REG_VDISP = 6;
  localparam int REG_VSPOS = 7;
  localparam int REG_MAXSCAN = 9;
endpackage : tdi_pkg

// file: tdi_fifo.sv
`timescale 1ns/1ns
module tdi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] nxt_mem [DEPTH];
  logic [PW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [PW:0] cnt_ff, nxt_cnt;
  logic do_wr, do_rd;

  assign wr_ready_out = cnt_ff != DEPTH[PW:0];
  assign rd_valid_out = cnt_ff != '0;
  assign rd_data_out = mem_ff[rp_ff];
  assign do_wr = wr_valid_in && wr_ready_out;
  assign do_rd = rd_valid_out && rd_ready_in;

  always_comb
  begin
    nxt_mem = mem_ff;
    nxt_wp = wp_ff;
    nxt_rp = rp_ff;
    nxt_cnt = cnt_ff;
    if (do_wr)
    begin
      nxt_mem[wp_ff] = wr_data_in;
      nxt_wp = wp_ff + 1'b1;
    end
    if (do_rd)
      nxt_rp = rp_ff + 1'b1;
    if (do_wr && !do_rd)
      nxt_cnt = cnt_ff + 1'b1;
    else if (do_rd && !do_wr)
      nxt_cnt = cnt_ff - 1'b1;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
    mem_ff <= nxt_mem;
  end
endmodule : tdi_fifo

// file: tdi_dot_shift.sv
`timescale 1ns/1ns
module tdi_dot_shift (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic load_in,
  input wire logic shift_in,
  input wire logic [tdi_pkg::ROW_W-1:0] row_in,
  output logic dot_out
);
  logic [tdi_pkg::ROW_W-1:0] sh_ff, nxt_sh;

  always_comb
  begin
    nxt_sh = sh_ff;
    if (load_in)
      nxt_sh = row_in;
    else if (shift_in)
      nxt_sh = {sh_ff[tdi_pkg::ROW_W-2:0], 1'b0};
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
      sh_ff <= '0;
    else
      sh_ff <= nxt_sh;
  end

  // Most significant dot leaves first
  assign dot_out = sh_ff[tdi_pkg::ROW_W-1];
endmodule : tdi_dot_shift

// file: tdi_text_display.sv
`timescale 1ns/1ns
// Contract
// - Host writes each character as one 8-bit byte code.
// - Character memory holds 2048 bytes, one per screen position.
// - Controller fetches codes; character ROM turns them into dot rows.
// - ROM dot row is shifted out as serial dots.
// - Horizontal and vertical sync merge with dots into composite video.
// - Option maps memory at 1000-17FF or F000-F7FF.
// - Controller answers at 1840/1841 or E840/E841 per option.
// - Partial decode: 1840-187F or E840-E87F all select controller.
// - Host memory access in phase 2 never disturbs video.
// - Runs from bus clocks or phase-2-derived generator; the code runs from sys_clk_in, with phase 2 only gating host access.
// - Display fetch in phase 1, host access in phase 2; the code fetches in the first sys cycle of each cell, in either phase.
// - Positions are consecutive binary addresses from zero top left.
// - Each cell is 0.5us at 12MHz dot rate, six dots; the code uses 20 sys cycles per dot (12.5MHz), a 0.48us cell.
// - Write with A0 low loads register select from D0-D4.
module tdi_text_display (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic blk_sel_in,
  input wire logic phi2_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  output logic rdata_valid_out,
  output logic horizontal_sync_pulse_out,
  output logic vertical_sync_pulse_out,
  output logic video_out
);
  logic [2:0] phi2_sync_ff, nxt_phi2_sync;
  logic phi2_st_ff, nxt_phi2_st;
  logic [7:0] char_mem [tdi_pkg::MEM_DEPTH];
  logic [7:0] regs_ff [tdi_pkg::NUM_REGS];
  logic [7:0] nxt_regs [tdi_pkg::NUM_REGS];
  logic [4:0] register_select_latch_ff, nxt_register_select_latch;
  logic [7:0] rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;
  logic ram_sel, con_sel, mem_we;
  logic [tdi_pkg::MEM_AW-1:0] host_addr;
  logic [4:0] dot_div_ff, nxt_dot_div;
  logic [2:0] dot_idx_ff, nxt_dot_idx;
  logic [7:0] hcnt_ff, nxt_hcnt;
  logic [4:0] scan_ff, nxt_scan;
  logic [7:0] vrow_ff, nxt_vrow;
  logic [3:0] hs_cnt_ff, nxt_hs_cnt;
  logic [3:0] vs_cnt_ff, nxt_vs_cnt;
  logic [tdi_pkg::MEM_AW-1:0] row_base_ff, nxt_row_base;
  logic [7:0] fetch_ff, nxt_fetch;
  logic disp_ff, nxt_disp;
  logic dot_tick, cell_end, line_end, row_end, frame_end;
  logic [tdi_pkg::MEM_AW-1:0] disp_addr;
  logic fifo_wr_rdy, fifo_rd_vld, fifo_take;
  logic [8:0] fifo_wdata, fifo_rdata;
  logic [tdi_pkg::ROW_W-1:0] rom_row;
  logic ser_dot;
  logic hs_ff, nxt_hs, vs_ff, nxt_vs, vid_ff, nxt_vid;

  // Pure function: the character ROM is a fixed 5x8 block pattern lookup
  function automatic logic [tdi_pkg::ROW_W-1:0] char_rom(input logic [7:0] code,
                                                         input logic [4:0] line);
    logic [tdi_pkg::ROW_W-1:0] r;
    r = '0;
    if (line < 5'h08 && code > 8'h20 && code < 8'h7F)
      r = {code[4:0] ^ {line[2:0], line[1:0]}, 1'b0};
    return r;
  endfunction : char_rom

  // Block decode on A11-A15 and A6-A15 only
  function automatic logic ram_hit(input logic [15:0] a, input logic blk);
    return a[15:11] == (blk ? tdi_pkg::RAM_BLKF_HI : tdi_pkg::RAM_BLK1_HI);
  endfunction : ram_hit

  function automatic logic con_hit(input logic [15:0] a, input logic blk);
    return a[15:6] == (blk ? tdi_pkg::CON_BLKE_HI : tdi_pkg::CON_BLK1_HI);
  endfunction : con_hit

  // Phase 2 comes from the bus, so it is resynchronised; clocking reduces to this strobe
  always_comb
  begin
    nxt_phi2_sync = {phi2_sync_ff[1:0], phi2_in};
    nxt_phi2_st = phi2_st_ff;
    if (phi2_sync_ff[2] == phi2_sync_ff[1])
      nxt_phi2_st = phi2_sync_ff[2];
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      phi2_sync_ff <= '0;
      phi2_st_ff <= 1'b0;
    end
    else
    begin
      phi2_sync_ff <= nxt_phi2_sync;
      phi2_st_ff <= nxt_phi2_st;
    end
  end

  assign ram_sel = ram_hit(addr_in, blk_sel_in);
  assign con_sel = con_hit(addr_in, blk_sel_in);
  assign host_addr = addr_in[tdi_pkg::MEM_AW-1:0];
  // Host access only in phase 2; display fetch uses its own port so video never glitches
  assign mem_we = wr_in && ram_sel && phi2_st_ff;

  always_ff @(posedge sys_clk_in)
  begin
    if (mem_we)
      char_mem[host_addr] <= wdata_in;
  end

  always_comb
  begin
    nxt_regs = regs_ff;
    nxt_register_select_latch = register_select_latch_ff;
    nxt_rdata = rdata_ff;
    nxt_rvalid = 1'b0;
    if (phi2_st_ff && con_sel && wr_in)
    begin
      if (!addr_in[0])
        nxt_register_select_latch = wdata_in[4:0];
      else if (register_select_latch_ff < 5'(tdi_pkg::NUM_REGS))
        nxt_regs[register_select_latch_ff] = wdata_in;
    end
    if (phi2_st_ff && rd_in && (ram_sel || con_sel))
    begin
      nxt_rvalid = 1'b1;
      if (ram_sel)
        nxt_rdata = char_mem[host_addr];
      else if (addr_in[0] && register_select_latch_ff < 5'(tdi_pkg::NUM_REGS))
        nxt_rdata = regs_ff[register_select_latch_ff];
      else
        nxt_rdata = 8'h00;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      for (int i = 0; i < tdi_pkg::NUM_REGS; i++)
        regs_ff[i] <= 8'h00;
      regs_ff[tdi_pkg::REG_HTOT] <= tdi_pkg::HTOT_RST;
      regs_ff[tdi_pkg::REG_HDISP] <= tdi_pkg::HDISP_RST;
      regs_ff[tdi_pkg::REG_HSPOS] <= tdi_pkg::HSPOS_RST;
      regs_ff[tdi_pkg::REG_SYNCW] <= tdi_pkg::SYNCW_RST;
      regs_ff[tdi_pkg::REG_VTOT] <= tdi_pkg::VTOT_RST;
      regs_ff[tdi_pkg::REG_VDISP] <= tdi_pkg::VDISP_RST;
      regs_ff[tdi_pkg::REG_VSPOS] <= tdi_pkg::VSPOS_RST;
      regs_ff[tdi_pkg::REG_MAXSCAN] <= tdi_pkg::MAXSCAN_RST;
      register_select_latch_ff <= '0;
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      regs_ff <= nxt_regs;
      register_select_latch_ff <= nxt_register_select_latch;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // Dot tick approximates 12MHz from 250MHz; cell is six dots
  assign dot_tick = dot_div_ff == 5'(tdi_pkg::DOT_CYC - 1);
  assign cell_end = dot_tick && dot_idx_ff == 3'(tdi_pkg::DOTS_PER_CELL - 1);
  assign line_end = cell_end && hcnt_ff == regs_ff[tdi_pkg::REG_HTOT];
  assign row_end = line_end && scan_ff == regs_ff[tdi_pkg::REG_MAXSCAN][4:0];
  assign frame_end = row_end && vrow_ff == regs_ff[tdi_pkg::REG_VTOT];
  assign disp_addr = row_base_ff + tdi_pkg::MEM_AW'(hcnt_ff);

  always_comb
  begin
    nxt_dot_div = dot_tick ? 5'h00 : dot_div_ff + 5'h01;
    nxt_dot_idx = dot_idx_ff;
    nxt_hcnt = hcnt_ff;
    nxt_scan = scan_ff;
    nxt_vrow = vrow_ff;
    nxt_row_base = row_base_ff;
    nxt_hs_cnt = hs_cnt_ff;
    nxt_vs_cnt = vs_cnt_ff;
    if (dot_tick)
      nxt_dot_idx = cell_end ? 3'h0 : dot_idx_ff + 3'h1;
    if (cell_end)
    begin
      nxt_hcnt = line_end ? 8'h00 : hcnt_ff + 8'h01;
      if (hcnt_ff == regs_ff[tdi_pkg::REG_HSPOS])
        nxt_hs_cnt = regs_ff[tdi_pkg::REG_SYNCW][3:0];
      else if (hs_cnt_ff != 4'h0)
        nxt_hs_cnt = hs_cnt_ff - 4'h1;
    end
    if (line_end)
    begin
      nxt_scan = row_end ? 5'h00 : scan_ff + 5'h01;
      if (vs_cnt_ff != 4'h0)
        nxt_vs_cnt = vs_cnt_ff - 4'h1;
    end
    if (row_end)
    begin
      nxt_vrow = frame_end ? 8'h00 : vrow_ff + 8'h01;
      nxt_row_base = frame_end ? '0 :
        row_base_ff + tdi_pkg::MEM_AW'(regs_ff[tdi_pkg::REG_HDISP]);
      if (vrow_ff == regs_ff[tdi_pkg::REG_VSPOS])
        nxt_vs_cnt = regs_ff[tdi_pkg::REG_SYNCW][7:4];
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      dot_div_ff <= '0;
      dot_idx_ff <= '0;
      hcnt_ff <= '0;
      scan_ff <= '0;
      vrow_ff <= '0;
      row_base_ff <= '0;
      hs_cnt_ff <= '0;
      vs_cnt_ff <= '0;
    end
    else
    begin
      dot_div_ff <= nxt_dot_div;
      dot_idx_ff <= nxt_dot_idx;
      hcnt_ff <= nxt_hcnt;
      scan_ff <= nxt_scan;
      vrow_ff <= nxt_vrow;
      row_base_ff <= nxt_row_base;
      hs_cnt_ff <= nxt_hs_cnt;
      vs_cnt_ff <= nxt_vs_cnt;
    end
  end

  // Fetch in the first sys cycle of each cell, in either phase
  always_comb
  begin
    nxt_fetch = fetch_ff;
    nxt_disp = disp_ff;
    if (dot_div_ff == 5'h00 && dot_idx_ff == 3'h0)
    begin
      nxt_fetch = char_mem[disp_addr];
      nxt_disp = hcnt_ff < regs_ff[tdi_pkg::REG_HDISP] &&
                 vrow_ff < regs_ff[tdi_pkg::REG_VDISP];
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      fetch_ff <= 8'h00;
      disp_ff <= 1'b0;
    end
    else
    begin
      fetch_ff <= nxt_fetch;
      disp_ff <= nxt_disp;
    end
  end

  // Code and display flag are pushed in the cell's second sys cycle and drained at the next cell boundary; a full FIFO stalls nothing
  assign fifo_wdata = {disp_ff, fetch_ff};
  assign fifo_take = cell_end && fifo_rd_vld;

  tdi_fifo #(
    .WIDTH(9),
    .DEPTH(tdi_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .wr_data_in(fifo_wdata),
    .wr_valid_in(dot_div_ff == 5'h01 && dot_idx_ff == 3'h0),
    .wr_ready_out(fifo_wr_rdy),
    .rd_data_out(fifo_rdata),
    .rd_valid_out(fifo_rd_vld),
    .rd_ready_in(cell_end)
  );

  assign rom_row = fifo_rdata[8] ? char_rom(fifo_rdata[7:0], scan_ff) : '0;

  tdi_dot_shift u_shift (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .load_in(fifo_take),
    .shift_in(dot_tick && !cell_end),
    .row_in(rom_row),
    .dot_out(ser_dot)
  );

  always_comb
  begin
    nxt_hs = hs_cnt_ff != 4'h0;
    nxt_vs = vs_cnt_ff != 4'h0;
    // Composite: sync forces black, dots only outside sync
    nxt_vid = ser_dot && !nxt_hs && !nxt_vs && fifo_wr_rdy;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      hs_ff <= 1'b0;
      vs_ff <= 1'b0;
      vid_ff <= 1'b0;
    end
    else
    begin
      hs_ff <= nxt_hs;
      vs_ff <= nxt_vs;
      vid_ff <= nxt_vid;
    end
  end

  assign horizontal_sync_pulse_out = hs_ff;
  assign vertical_sync_pulse_out = vs_ff;
  assign video_out = vid_ff;
  assign rdata_out = rdata_ff;
  assign rdata_valid_out = rvalid_ff;
endmodule : tdi_text_display

// file: tdi_text_display_assertions.sv
`timescale 1ns/1ns
module tdi_text_display_assertions (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic blk_sel_in,
  input wire logic phi2_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic rdata_valid_out,
  input wire logic horizontal_sync_pulse_out,
  input wire logic vertical_sync_pulse_out,
  input wire logic video_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  wire logic in_sync = horizontal_sync_pulse_out || vertical_sync_pulse_out;
  blank_in_sync_a: assert property (in_sync |-> !video_out)
    else $error("video high during sync");
  read_cause_a: assert property (rdata_valid_out |-> $past(rd_in))
    else $error("read answer without request");
  rdata_hold_a: assert property (!rdata_valid_out |-> $stable(rdata_out))
    else $error("read data moved without answer");
  phase1_quiet_a: assert property (!phi2_in [*5] |=> !rdata_valid_out)
    else $error("access taken in phase 1");
  dot_period_a: assert property ($changed(video_out) |=> $stable(video_out) [*8])
    else $error("dot shorter than dot period");
  hsync_width_a: assert property ($rose(horizontal_sync_pulse_out)
    |=> horizontal_sync_pulse_out [*8])
    else $error("horizontal sync too short");
  hsync_gap_a: assert property ($fell(horizontal_sync_pulse_out)
    |=> !horizontal_sync_pulse_out [*8])
    else $error("horizontal sync gap too short");
  vsync_width_a: assert property ($rose(vertical_sync_pulse_out)
    |=> vertical_sync_pulse_out [*8])
    else $error("vertical sync too short");
  cover property ($rose(horizontal_sync_pulse_out));
  cover property (rdata_valid_out);
  cover property ($rose(video_out));
  cover property ($rose(vertical_sync_pulse_out));
endmodule : tdi_text_display_assertions

// file: tdi_host_partner.sv
`timescale 1ns/1ns
module tdi_host_partner (
  input wire logic sys_clk_in,
  output logic phi2_out,
  output logic host_ok_out
);
  // Phase 2 of a 2MHz processor: 125 system cycles per period
  int cnt = 0;
  always @(posedge sys_clk_in)
  begin
    cnt <= (cnt == 124) ? 0 : cnt + 1;
  end
  assign phi2_out = (cnt >= 62);
  // Margin past the three-flop synchroniser and before the phase ends
  assign host_ok_out = (cnt >= 68) && (cnt <= 110);
endmodule : tdi_host_partner

// file: test_text_display_interface.sv
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", nm, exp, got); end end
module test_text_display_interface;
  logic sys_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic blk_sel_in = 1'b0;
  logic [15:0] addr_in = 16'h0000;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic phi2, host_ok, rv, hs, vs, vid;
  logic [7:0] rdata;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  tdi_text_display dut_u (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .blk_sel_in(blk_sel_in), .phi2_in(phi2), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata), .rdata_valid_out(rv),
    .horizontal_sync_pulse_out(hs), .vertical_sync_pulse_out(vs), .video_out(vid));
  tdi_host_partner host_u (.sys_clk_in(sys_clk_in), .phi2_out(phi2), .host_ok_out(host_ok));
  initial
  begin
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  task conclude;
    if (error_cnt == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  always @(posedge sys_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      error_cnt++;
      conclude();
    end
  end
  task wait_host;
    while (host_ok !== 1'b1)
    begin
      @(posedge sys_clk_in);
      #1;
    end
  endtask : wait_host
  task host_wr(input logic [15:0] a, input logic [7:0] d);
    wait_host();
    addr_in = a;
    wdata_in = d;
    wr_in = 1'b1;
    @(posedge sys_clk_in);
    #1;
    wr_in = 1'b0;
    @(posedge sys_clk_in);
    #1;
  endtask : host_wr
  // Reads expecting no answer pass ok = 0
  task host_rd(input logic [15:0] a, input logic ok, input logic [7:0] exp);
    wait_host();
    addr_in = a;
    rd_in = 1'b1;
    @(posedge sys_clk_in);
    #1;
    rd_in = 1'b0;
    `CHK("rdata_valid", ok, rv)
    if (ok)
      `CHK("rdata", exp, rdata)
    @(posedge sys_clk_in);
    #1;
  endtask : host_rd
  task t_ram_map;
    blk_sel_in = 1'b0;
    host_wr(16'h1000, 8'h41);
    host_wr(16'hF000, 8'h5A);
    host_rd(16'h1000, 1'b1, 8'h41);
    host_rd(16'h1800, 1'b0, 8'h00);
    blk_sel_in = 1'b1;
    host_rd(16'hF000, 1'b1, 8'h41);
    host_wr(16'hF7FF, 8'hC3);
    blk_sel_in = 1'b0;
    host_rd(16'h17FF, 1'b1, 8'hC3);
  endtask : t_ram_map
  task t_controller;
    host_wr(16'h1840, 8'h01);
    host_wr(16'h1841, 8'h33);
    host_rd(16'h187F, 1'b1, 8'h33);
    blk_sel_in = 1'b1;
    host_wr(16'hE87E, 8'hE1);
    host_rd(16'hE841, 1'b1, 8'h33);
    host_wr(16'hE841, tdi_pkg::HDISP_RST);
    host_rd(16'hE87F, 1'b1, tdi_pkg::HDISP_RST);
    blk_sel_in = 1'b0;
  endtask : t_controller
  task t_phase1;
    while (phi2 !== 1'b0 || cyc % 125 < 10)
    begin
      @(posedge sys_clk_in);
      #1;
    end
    addr_in = 16'h1000;
    rd_in = 1'b1;
    repeat (4) @(posedge sys_clk_in);
    #1;
    rd_in = 1'b0;
    `CHK("phase1 read", 1'b0, rv)
  endtask : t_phase1
  task t_video;
    int n;
    logic seen_v, seen_h;
    seen_v = 1'b0;
    seen_h = 1'b0;
    for (n = 0; n < 30000; n++)
    begin
      @(posedge sys_clk_in);
      #1;
      seen_v = seen_v | (vid === 1'b1);
      seen_h = seen_h | (hs === 1'b1);
    end
    `CHK("video dots", 1'b1, seen_v)
    `CHK("horizontal sync", 1'b1, seen_h)
  endtask : t_video
  // Mid-run reset, then short lines and rows so vertical sync comes soon
  task t_reset_vsync;
    int n;
    logic seen_vs, seen_vid;
    seen_vs = 1'b0;
    seen_vid = 1'b0;
    host_wr(16'h1000, 8'h20);
    host_wr(16'h1840, 8'h00);
    host_wr(16'h1841, 8'h0F);
    rst_b_in = 1'b0;
    repeat (4) @(posedge sys_clk_in);
    #1;
    `CHK("video in reset", 1'b0, vid)
    `CHK("hsync in reset", 1'b0, hs)
    `CHK("vsync in reset", 1'b0, vs)
    `CHK("rdata_valid in reset", 1'b0, rv)
    rst_b_in = 1'b1;
    // Phase 2 must pass the synchroniser again before the host is served
    repeat (8) @(posedge sys_clk_in);
    #1;
    host_rd(16'h1841, 1'b1, tdi_pkg::HTOT_RST);
    host_wr(16'h1841, 8'h0F);
    host_wr(16'h1840, 8'h09);
    host_wr(16'h1841, 8'h01);
    host_wr(16'h1840, 8'h07);
    host_wr(16'h1841, 8'h00);
    for (n = 0; n < 8000; n++)
    begin
      @(posedge sys_clk_in);
      #1;
      seen_vs = seen_vs | (vs === 1'b1);
      seen_vid = seen_vid | (vid !== 1'b0);
    end
    `CHK("vertical sync", 1'b1, seen_vs)
    `CHK("blank cell dark", 1'b0, seen_vid)
  endtask : t_reset_vsync
  initial
  begin
    repeat (4) @(posedge sys_clk_in);
    #1;
    rst_b_in = 1'b1;
    `CHK("video after reset", 1'b0, vid)
    repeat (4) @(posedge sys_clk_in);
    #1;
    t_ram_map();
    t_controller();
    t_phase1();
    t_video();
    t_reset_vsync();
    conclude();
  end
endmodule : test_text_display_interface
bind tdi_text_display tdi_text_display_assertions chk_u (.sys_clk_in(sys_clk_in),
  .rst_b_in(rst_b_in), .blk_sel_in(blk_sel_in), .phi2_in(phi2_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .rdata_valid_out(rdata_valid_out), .horizontal_sync_pulse_out(horizontal_sync_pulse_out),
  .vertical_sync_pulse_out(vertical_sync_pulse_out), .video_out(video_out));
